// ==== verilog/param_command_access_control.sv ====
// Parameter command interpreter and access control with an APB register port.
// Assumes pins are asynchronous and the parameter store acts on the event pulses.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns

module param_command_access_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_button,
  input wire logic reset_input,
  input wire logic undervoltage,
  input wire logic drive_enabled,
  input wire logic menu0_enter,
  output param_cmd_pkg::access_s access,
  output param_cmd_pkg::event_s events,
  output logic show_nondefault,
  output logic show_destinations
);

  // ************************************************************
  // State of the block.
  // ************************************************************
  typedef struct packed {
    logic [param_cmd_pkg::pin_count-1:0] sync_a; // First synchroniser stage.
    logic [param_cmd_pkg::pin_count-1:0] sync_b; // Second synchroniser stage.
    logic [param_cmd_pkg::pin_count-1:0] pin_prev; // Previous synchronised pin levels.
    logic [31:0] command; // Command entry parameter.
    logic [2:0] level; // User security level.
    logic [30:0] code; // User security code.
    logic code_active; // Code has been activated by a reset.
    logic unlocked; // Correct code offered since activation.
    logic [1:0] op_mode; // Selected operating mode.
    logic [1:0] loaded_mode; // Mode whose defaults are loaded.
    logic filt_nd; // Non-default filter on.
    logic filt_dst; // Destination filter on.
    logic reset_pending; // Drive reset requested through the port.
    param_cmd_pkg::access_s access; // Registered access rights.
    param_cmd_pkg::event_s events; // Registered event pulses.
    logic [31:0] prdata; // Registered read data.
    logic pready; // Registered ready.
    logic pslverr; // Registered error.
  } state_s;

  state_s r; // Current state.
  state_s next_r; // Next state.

  logic [param_cmd_pkg::pin_count-1:0] pin; // Synchronised pin levels.
  logic [param_cmd_pkg::pin_count-1:0] pin_rise; // Rising edges of pins.
  logic apb_done; // Access phase completes at this edge.
  logic apb_wr; // Write takes effect at this edge.
  logic locked; // Code active and not unlocked.
  logic do_reset; // Drive reset happens this cycle.
  logic mapped; // Address hits a register.
  logic [31:0] rd_word; // Read data for the current address.

  // ************************************************************
  // Decode helpers.
  // ************************************************************

  // Only the second synchroniser stage and later flops are read here.
  // The first stage may go metastable, so no logic reads it.
  assign pin = r.sync_b;
  assign pin_rise = r.sync_b & ~r.pin_prev;

  // Ready is registered, so a transfer completes on the second access cycle.
  // Setup cycles must keep penable low, or ready would repeat.
  assign apb_done = psel && penable && r.pready;
  assign apb_wr = apb_done && pwrite && !r.pslverr;

  // A locked code blocks command, code and mode writes until unlocked.
  assign locked = r.code_active && !r.unlocked;

  // A drive reset comes from the button, any toggle of the reset input, or the port.
  // Comparing settled levels lets either edge of the input count.
  assign do_reset = pin_rise[param_cmd_pkg::pin_reset_button] ||
    (pin[param_cmd_pkg::pin_reset_input] != r.pin_prev[param_cmd_pkg::pin_reset_input]) ||
    r.reset_pending;

  // Address decode and read mux; the code reads as zero once activated.
  always_comb begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      param_cmd_pkg::off_command_entry_param: begin
        rd_word = r.command;
      end
      param_cmd_pkg::off_reset_request: begin
        rd_word = 32'h0000_0000;
      end
      param_cmd_pkg::off_security_level: begin
        rd_word = {29'h0000_0000, r.level};
      end
      param_cmd_pkg::off_security_code: begin
        // Hiding the code keeps it from being read back over comms.
        rd_word = r.code_active ? 32'h0000_0000 : {1'b0, r.code};
      end
      param_cmd_pkg::off_unlock_code: begin
        rd_word = 32'h0000_0000;
      end
      param_cmd_pkg::off_operating_mode: begin
        rd_word = {30'h0000_0000, r.op_mode};
      end
      param_cmd_pkg::off_status: begin
        rd_word = {22'h00_0000, pin[param_cmd_pkg::pin_drive_enabled], pin[param_cmd_pkg::pin_undervoltage],
          r.loaded_mode, r.filt_dst, r.filt_nd, locked, r.unlocked, r.code_active, r.reset_pending};
      end
      param_cmd_pkg::off_access: begin
        rd_word = {26'h000_0000, r.access};
      end
      default: begin
        // Unmapped addresses answer with an error and zero data.
        mapped = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Next-state logic.
  // ************************************************************
  always_comb begin
    next_r = r;

    // Synchronisers and edge history.
    next_r.sync_a = {menu0_enter, drive_enabled, undervoltage, reset_input, reset_button};
    next_r.sync_b = r.sync_a;
    next_r.pin_prev = r.sync_b;

    // Event outputs are one-cycle pulses by default.
    // The parameter store must act on a pulse in its one cycle.
    next_r.events = '0;

    // APB answer: ready rises one cycle into the access phase, then drops.
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    if (psel && penable && !r.pready) begin
      next_r.pready = 1'b1;
      next_r.pslverr = !mapped;
      next_r.prdata = pwrite ? 32'h0000_0000 : rd_word;
    end

    // Enter leaving Menu 0 edit mode stores just that parameter.
    // Advanced menu edits raise no store here; only a save command keeps them.
    if (pin_rise[param_cmd_pkg::pin_menu0_enter]) begin
      next_r.events.nv_store_param = 1'b1;
    end

    // A drive reset consumes the request and the command and relocks editing.
    // Clearing before the writes lets a write in the same cycle win.
    if (do_reset) begin
      next_r.reset_pending = 1'b0;
      next_r.command = param_cmd_pkg::cmd_no_action;
      next_r.unlocked = 1'b0;
    end

    // Register writes.
    if (apb_wr) begin
      unique case (paddr)
        param_cmd_pkg::off_command_entry_param: begin
          if (!locked) begin
            next_r.command = pwdata;
            // Display filters act at once and need no reset.
            if (pwdata == param_cmd_pkg::cmd_show_nondefault) begin
              next_r.filt_nd = 1'b1;
              next_r.filt_dst = 1'b0;
            end else if (pwdata == param_cmd_pkg::cmd_show_destinations) begin
              next_r.filt_dst = 1'b1;
              next_r.filt_nd = 1'b0;
            end else if (pwdata == param_cmd_pkg::cmd_no_action) begin
              next_r.filt_nd = 1'b0;
              next_r.filt_dst = 1'b0;
            end
          end
        end
        param_cmd_pkg::off_reset_request: begin
          if (pwdata == param_cmd_pkg::reset_request_code) begin
            next_r.reset_pending = 1'b1;
          end
        end
        param_cmd_pkg::off_security_level: begin
          // The level stays changeable while a code is locked; higher values are ignored.
          // This is the keypad path that must work while locked.
          if (pwdata <= {29'h0000_0000, param_cmd_pkg::level_no_access}) begin
            next_r.level = pwdata[2:0];
          end
        end
        param_cmd_pkg::off_security_code: begin
          if (!locked) begin
            if (pwdata == 32'h0000_0000) begin
              // Zero after unlock removes security for good.
              next_r.code = param_cmd_pkg::code_reset;
              next_r.code_active = 1'b0;
              next_r.unlocked = 1'b0;
            end else if (!pwdata[31]) begin
              // Codes with the top bit set lie outside the legal range.
              next_r.code = pwdata[30:0];
            end
          end
        end
        param_cmd_pkg::off_unlock_code: begin
          if (locked) begin
            // Only a locked block checks the offer; otherwise no pulse.
            if (pwdata == {1'b0, r.code}) begin
              next_r.unlocked = 1'b1;
              next_r.events.edit_granted = 1'b1;
            end else begin
              next_r.events.bad_code = 1'b1;
            end
          end
        end
        param_cmd_pkg::off_operating_mode: begin
          // Only the three mode codes are accepted.
          if (!locked && (pwdata[31:2] == 30'h0000_0000) && (pwdata[1:0] != 2'h0)) begin
            next_r.op_mode = pwdata[1:0];
          end
        end
        default: begin
          // Read-only and unmapped addresses store nothing.
        end
      endcase
    end

    // ************************************************************
    // Drive reset actions.
    // ************************************************************

    // Drive reset executes the pending command held from before this edge.
    if (do_reset) begin
      next_r.events.drive_reset = 1'b1;
      // Security: a set code becomes active and the display goes to Menu 0.
      if (r.code != param_cmd_pkg::code_reset) begin
        next_r.code_active = 1'b1;
        next_r.events.menu0_return = 1'b1;
      end
      unique case (r.command)
        param_cmd_pkg::cmd_save: begin
          // In undervoltage the plain save code does nothing.
          next_r.events.nv_save_all = !pin[param_cmd_pkg::pin_undervoltage];
        end
        param_cmd_pkg::cmd_save_uv: begin
          // Outside undervoltage the alternate code saves nothing.
          next_r.events.nv_save_all = pin[param_cmd_pkg::pin_undervoltage];
        end
        param_cmd_pkg::cmd_defaults_50, param_cmd_pkg::cmd_defaults_60: begin
          // Defaults are refused while the drive is enabled; level and code are kept.
          if (!pin[param_cmd_pkg::pin_drive_enabled]) begin
            // The two load flags are exclusive, as the codes differ.
            next_r.events.load_50hz = (r.command == param_cmd_pkg::cmd_defaults_50);
            next_r.events.load_60hz = (r.command == param_cmd_pkg::cmd_defaults_60);
            next_r.events.nv_save_all = 1'b1;
          end
        end
        param_cmd_pkg::cmd_mode_50, param_cmd_pkg::cmd_mode_60: begin
          // Mode defaults load only when the mode selection differs from the loaded one.
          // Loading again for the same selection would wipe settings for nothing.
          if (!pin[param_cmd_pkg::pin_drive_enabled] && (r.op_mode != r.loaded_mode)) begin
            next_r.events.load_mode = 1'b1;
            next_r.events.load_50hz = (r.command == param_cmd_pkg::cmd_mode_50);
            next_r.events.load_60hz = (r.command == param_cmd_pkg::cmd_mode_60);
            next_r.loaded_mode = r.op_mode;
          end
        end
        default: begin
          // Other codes have no reset action.
        end
      endcase
    end

    // Access rights from the level and the lock, registered for the outputs.
    // Registering costs a cycle of lag but keeps the rights glitch free.
    next_r.access = '0;
    next_r.access.comms_allowed = 1'b1;
    unique case (r.level)
      param_cmd_pkg::level_menu0: begin
        next_r.access.menu0_visible = 1'b1;
        next_r.access.menu0_writable = !locked;
      end
      param_cmd_pkg::level_all_menus: begin
        next_r.access.menu0_visible = 1'b1;
        next_r.access.adv_visible = 1'b1;
        next_r.access.menu0_writable = !locked;
        next_r.access.adv_writable = !locked;
      end
      param_cmd_pkg::level_ro_menu0: begin
        next_r.access.menu0_visible = 1'b1;
      end
      param_cmd_pkg::level_read_only: begin
        next_r.access.menu0_visible = 1'b1;
        next_r.access.adv_visible = 1'b1;
      end
      param_cmd_pkg::level_status_only: begin
        next_r.access.status_only = 1'b1;
      end
      param_cmd_pkg::level_no_access: begin
        next_r.access.status_only = 1'b1;
        next_r.access.comms_allowed = 1'b0;
      end
      default: begin
        // Codes 6 and 7 cannot be written; treat them as no access to be safe.
        next_r.access.status_only = 1'b1;
        next_r.access.comms_allowed = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // State register.
  // ************************************************************

  // Reset gives Menu 0 access, security open, no code and no filters.
  // Only constants load in reset, so the reset path holds no logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.level <= param_cmd_pkg::level_reset;
      r.code <= param_cmd_pkg::code_reset;
      r.op_mode <= param_cmd_pkg::mode_reset;
      r.loaded_mode <= param_cmd_pkg::mode_reset;
      r.access.menu0_visible <= 1'b1;
      r.access.menu0_writable <= 1'b1;
      r.access.comms_allowed <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ************************************************************
  // Outputs, all straight from the state register.
  // ************************************************************
  // Each output settles one cycle after the next-state logic decides it.
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign access = r.access;
  assign events = r.events;
  assign show_nondefault = r.filt_nd;
  assign show_destinations = r.filt_dst;

endmodule

// ==== verilog/param_cmd_pkg.sv ====
// Package for the parameter command interpreter and access-control block.
// Assumes a single 100 MHz control clock and an APB register port.
package param_cmd_pkg;

  // ************************************************************
  // Register map, byte addresses on the APB port.
  // ************************************************************
  localparam logic [7:0] off_command_entry_param = 8'h00; // Command entry parameter.
  localparam logic [7:0] off_reset_request = 8'h04; // Writing the reset code starts a drive reset.
  localparam logic [7:0] off_security_level = 8'h08; // User security level 0 to 5.
  localparam logic [7:0] off_security_code = 8'h0c; // User security code.
  localparam logic [7:0] off_unlock_code = 8'h10; // Code offered to unlock editing.
  localparam logic [7:0] off_operating_mode = 8'h14; // Operating mode selection.
  localparam logic [7:0] off_status = 8'h18; // Read-only block state.
  localparam logic [7:0] off_access = 8'h1c; // Read-only access rights.

  // ************************************************************
  // Command codes.
  // ************************************************************
  localparam logic [31:0] cmd_no_action = 32'h0000_0000; // No action, cancels display filters.
  localparam logic [31:0] cmd_save = 32'h0000_03e8; // 1000: save parameters.
  localparam logic [31:0] cmd_save_uv = 32'h0000_03e9; // 1001: save while in undervoltage.
  localparam logic [31:0] cmd_defaults_50 = 32'h0000_04d1; // 1233: restore 50 Hz defaults.
  localparam logic [31:0] cmd_defaults_60 = 32'h0000_04dc; // 1244: restore 60 Hz defaults.
  localparam logic [31:0] cmd_mode_50 = 32'h0000_04e5; // 1253: mode defaults, 50 Hz supply.
  localparam logic [31:0] cmd_mode_60 = 32'h0000_04e6; // 1254: mode defaults, 60 Hz supply.
  localparam logic [31:0] cmd_show_nondefault = 32'h0000_2ee0; // 12000: show non-default only.
  localparam logic [31:0] cmd_show_destinations = 32'h0000_2ee1; // 12001: show destinations only.
  localparam logic [31:0] reset_request_code = 32'h0000_0064; // 100: drive reset request.

  // ************************************************************
  // Security levels, operating modes and reset values.
  // ************************************************************
  localparam logic [2:0] level_menu0 = 3'h0; // Menu 0 only, editable.
  localparam logic [2:0] level_all_menus = 3'h1; // All menus, editable.
  localparam logic [2:0] level_ro_menu0 = 3'h2; // Menu 0 only, read-only.
  localparam logic [2:0] level_read_only = 3'h3; // All menus, read-only.
  localparam logic [2:0] level_status_only = 3'h4; // Keypad held in status mode.
  localparam logic [2:0] level_no_access = 3'h5; // Status mode and no comms access.
  localparam logic [1:0] mode_open_loop = 2'h1; // Open-loop.
  localparam logic [1:0] mode_rfc_a = 2'h2; // RFC-A.
  localparam logic [1:0] mode_rfc_s = 2'h3; // RFC-S.
  localparam logic [2:0] level_reset = 3'h0; // Menu 0 with security open.
  localparam logic [1:0] mode_reset = 2'h1; // Open-loop after reset.
  localparam logic [30:0] code_reset = 31'h0000_0000; // Zero means no code.

  // ************************************************************
  // Pin inputs, index into the synchroniser vector.
  // ************************************************************
  localparam int pin_count = 5; // Number of asynchronous pins.
  localparam int pin_reset_button = 0; // Red reset button, active high.
  localparam int pin_reset_input = 1; // Reset digital input, any toggle resets.
  localparam int pin_undervoltage = 2; // Undervoltage on low-voltage supply.
  localparam int pin_drive_enabled = 3; // Drive enabled.
  localparam int pin_menu0_enter = 4; // Enter key leaving Menu 0 edit mode.

  // ************************************************************
  // Packed carriers.
  // ************************************************************
  typedef struct packed {
    logic menu0_visible; // Menu 0 may be viewed.
    logic adv_visible; // Advanced menus may be viewed.
    logic menu0_writable; // Menu 0 may be edited.
    logic adv_writable; // Advanced menus may be edited.
    logic status_only; // Keypad held in status mode.
    logic comms_allowed; // Comms and fieldbus may reach parameters.
  } access_s;

  typedef struct packed {
    logic drive_reset; // Drive reset executed this cycle.
    logic nv_save_all; // Store all parameters to nonvolatile memory.
    logic nv_store_param; // Store the edited Menu 0 parameter.
    logic load_50hz; // Load 50 Hz defaults.
    logic load_60hz; // Load 60 Hz defaults.
    logic load_mode; // Load defaults of the new operating mode.
    logic menu0_return; // Display returns to Menu 0.
    logic edit_granted; // Unlock matched, enter edit mode.
    logic bad_code; // Unlock failed, show incorrect-code message.
  } event_s;

endpackage

// ==== sim/param_cmd_props.sv ====
// Concurrent checks on the ports of the parameter command block.
// Assumes one clock, pclk, and the asynchronous active-low reset presetn.
`timescale 1ns/1ns
module param_cmd_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reset_input,
  input wire logic menu0_enter,
  input param_cmd_pkg::access_s access,
  input param_cmd_pkg::event_s events,
  input wire logic show_nondefault,
  input wire logic show_destinations
);
  // All checks share the one clock and are quiet while reset is low.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A setup cycle is answered after exactly one wait state.
  apb_one_wait_a: assert property (psel && !penable |-> ##2 pready)
    else $error("pready not two cycles after setup");
  apb_err_ready_a: assert property (pslverr |-> pready && !$past(pready))
    else $error("pslverr without a fresh pready");
  filt_exclusive_a: assert property (!(show_nondefault && show_destinations))
    else $error("both display filters on");
  status_hides_a: assert property (access.status_only |-> !access.menu0_visible && !access.adv_visible)
    else $error("status mode shows parameters");
  write_needs_view_a: assert property (access.adv_writable |-> access.adv_visible && access.menu0_writable)
    else $error("advanced write without view");
  save_on_reset_a: assert property (events.nv_save_all || events.load_50hz || events.load_60hz
    |-> events.drive_reset)
    else $error("save or defaults outside a drive reset");
  mode_load_freq_a: assert property (events.load_mode |-> events.drive_reset && (events.load_50hz ^ events.load_60hz))
    else $error("mode defaults without one supply frequency");
  toggle_resets_a: assert property ($changed(reset_input) |-> ##[2:5] events.drive_reset)
    else $error("reset input toggle gave no drive reset");
  enter_stores_a: assert property ($rose(menu0_enter) |-> ##3 events.nv_store_param)
    else $error("enter key did not store the parameter");
  unlock_single_a: assert property (events.edit_granted |-> !events.bad_code ##1 !events.edit_granted)
    else $error("unlock answer not a single clean pulse");
endmodule
bind param_command_access_control param_cmd_props param_cmd_props_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .reset_input(reset_input),
  .menu0_enter(menu0_enter), .access(access), .events(events), .show_nondefault(show_nondefault),
  .show_destinations(show_destinations));

// ==== sim/operator_panel.sv ====
// Model of the operator panel that works the pins of the drive.
// Assumes one-cycle request pulses from the bench, on the rising edge.
`timescale 1ns/1ns
module operator_panel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic press_reset,
  input wire logic flip_reset,
  input wire logic press_enter,
  input wire logic low_supply,
  input wire logic run_enable,
  output logic reset_button,
  output logic reset_input,
  output logic undervoltage,
  output logic drive_enabled,
  output logic menu0_enter
);
  logic [2:0] btn_cnt; // Keeps the button down long enough for the synchroniser.
  logic [2:0] ent_cnt; // Same for the enter key.
  // Buttons are held four cycles, since a shorter press could slip past the pin filter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_cnt <= 3'h0;
      ent_cnt <= 3'h0;
      reset_input <= 1'b0;
    end else begin
      btn_cnt <= press_reset ? 3'h4 : (btn_cnt != 3'h0 ? btn_cnt - 3'h1 : 3'h0);
      ent_cnt <= press_enter ? 3'h4 : (ent_cnt != 3'h0 ? ent_cnt - 3'h1 : 3'h0);
      if (flip_reset) begin
        reset_input <= !reset_input;
      end
    end
  end
  assign reset_button = btn_cnt != 3'h0;
  assign menu0_enter = ent_cnt != 3'h0;
  assign undervoltage = low_supply;
  assign drive_enabled = run_enable;
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the parameter command block.
// Assumes the design answers APB after one wait state, as handed over.
`timescale 1ns/1ns
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h092326bf;
  logic pready, pslverr, rb, ri, uv, de, me, show_nd, show_dst;
  logic press_reset = 1'b0, flip_reset = 1'b0, press_enter = 1'b0, low_supply = 1'b0, run_enable = 1'b0;
  param_cmd_pkg::access_s access;
  param_cmd_pkg::event_s events;
  logic [32:0] exp_q [$]; // Expected {pslverr, prdata} of each transfer, oldest first.
  int fails = 0, n_tests = 0, i;
  // Command table: code, supply low, drive enabled, mode selection, expected events.
  logic [31:0] t_code [9] = '{32'h3e8, 32'h3e8, 32'h3e9, 32'h4d1, 32'h4dc, 32'h4dc, 32'h4e5, 32'h4e6, 32'h4e5};
  logic t_uv [9] = '{0, 1, 1, 0, 0, 0, 0, 0, 0};
  logic t_en [9] = '{0, 0, 0, 0, 1, 0, 0, 0, 0};
  logic [31:0] t_mode [9] = '{1, 1, 1, 1, 1, 1, 1, 2, 2};
  logic [8:0] t_ev [9] = '{9'h180, 9'h100, 9'h180, 9'h1a0, 9'h100, 9'h190, 9'h100, 9'h118, 9'h100};
  // Expected access vector for each security level while open.
  logic [31:0] t_acc [6] = '{32'h29, 32'h3d, 32'h21, 32'h31, 32'h03, 32'h02};
  always #5 pclk = !pclk;
  param_command_access_control param_command_access_control_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_button(rb), .reset_input(ri), .undervoltage(uv), .drive_enabled(de),
    .menu0_enter(me), .access(access), .events(events), .show_nondefault(show_nd), .show_destinations(show_dst));
  operator_panel operator_panel_i (.pclk(pclk), .presetn(presetn), .press_reset(press_reset),
    .flip_reset(flip_reset), .press_enter(press_enter), .low_supply(low_supply), .run_enable(run_enable),
    .reset_button(rb), .reset_input(ri), .undervoltage(uv), .drive_enabled(de), .menu0_enter(me));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer; the reply is judged by the monitor below.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
    int k;
    exp_q.push_back(exp);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
    if (k == 20) begin
      fails++;
      disable run_all;
    end
    {psel, penable} <= 2'b00;
  endtask
  // Waits a bounded time for the next event pulse and compares the whole vector.
  task automatic wev(input logic [8:0] exp);
    int k;
    for (k = 0; k < 40 && events === 9'h0; k++) @(posedge pclk);
    if (k == 40) begin
      fails++;
      disable run_all;
    end
    chk({24'h0, events}, {24'h0, exp});
  endtask
  task automatic pulse(input logic [2:0] m);
    {press_reset, flip_reset, press_enter} <= m;
    @(posedge pclk);
    {press_reset, flip_reset, press_enter} <= 3'h0;
  endtask
  // Filter levels are looked at one edge after the write that sets them.
  task automatic flt(input logic [1:0] exp);
    @(posedge pclk);
    chk({31'h0, show_nd, show_dst}, {31'h0, exp});
  endtask
  // Monitor: each pready takes the oldest expectation off the queue.
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) chk({pslverr, prdata}, 33'h1ffffffff);
      else chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  // The test sequence; a timeout disables it and falls through to the verdict.
  task run_all();
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h1c, 0, 33'h29);
    apb(0, 8'h20, 0, 33'h100000000);
    for (i = 0; i < 6; i++) begin
      apb(1, 8'h08, i, 0);
      apb(0, 8'h1c, 0, {1'b0, t_acc[i]});
      chk({27'h0, access}, {1'b0, t_acc[i]});
    end
    apb(1, 8'h08, 0, 0);
    $display("test levels done");
    apb(1, 8'h00, 32'h2ee0, 0);
    flt(2'h2);
    apb(1, 8'h00, 32'h2ee1, 0);
    flt(2'h1);
    apb(1, 8'h00, 32'h0, 0);
    flt(2'h0);
    $display("test filters done");
    for (i = 0; i < 9; i++) begin
      low_supply <= t_uv[i];
      run_enable <= t_en[i];
      apb(1, 8'h14, t_mode[i], 0);
      apb(1, 8'h00, t_code[i], 0);
      apb(0, 8'h00, 0, {1'b0, t_code[i]});
      if (i % 3 == 0) apb(1, 8'h04, 32'h64, 0);
      else if (i % 3 == 1) pulse(3'h4);
      else pulse(3'h2);
      wev(t_ev[i]);
      apb(0, 8'h00, 0, 0);
    end
    apb(1, 8'h14, 3, 0);
    apb(0, 8'h14, 0, 33'h3);
    apb(1, 8'h14, 0, 0);
    apb(0, 8'h14, 0, 33'h3);
    $display("test commands done");
    apb(1, 8'h0c, 32'h80000001, 0);
    apb(0, 8'h0c, 0, 0);
    apb(1, 8'h0c, 32'h5, 0);
    apb(0, 8'h0c, 0, 33'h5);
    apb(1, 8'h04, 32'h64, 0);
    wev(9'h104);
    apb(0, 8'h0c, 0, 0);
    apb(0, 8'h18, 0, 33'h8a);
    apb(0, 8'h1c, 0, 33'h21);
    apb(1, 8'h00, 32'h2ee0, 0);
    flt(2'h0);
    apb(1, 8'h08, 1, 0);
    apb(0, 8'h1c, 0, 33'h31);
    rnd = lfsr(rnd);
    apb(1, 8'h10, {1'b0, rnd[30:4], 4'h8}, 0);
    wev(9'h001);
    apb(1, 8'h10, 32'h5, 0);
    wev(9'h002);
    apb(0, 8'h1c, 0, 33'h3d);
    apb(0, 8'h08, 0, 33'h1);
    apb(1, 8'h0c, 0, 0);
    pulse(3'h4);
    wev(9'h100);
    apb(0, 8'h1c, 0, 33'h3d);
    $display("test security done");
    pulse(3'h1);
    wev(9'h040);
    $display("test enter done");
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    run_all();
    wrap_up();
  end
endmodule
